/* File: test/tb_adc_sequencer_result_fifos.sv */
`include "asf_consts.svh"
`default_nettype none

module tb_adc_sequencer_result_fifos;
  timeunit 1ns;
  timeprecision 1ps;
  import asf_pkg::*;

  // ========================================================================
  // Stimulus and observation
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bre = 1'b0;
  logic arv = 1'b0;
  logic rre = 1'b0;
  logic awr, wr, bv, arr, rv, irq;
  logic [11:0] awa = 12'h000;
  logic [11:0] ara = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rd, v;
  logic [1:0] br, rr, resp;
  logic [3:0] cmask1;
  logic [15:0] sel1;
  asf_push_t push = '0;
  logic [9:0] exp1 [4] = '{10'h001, 10'h00a, 10'h00b, 10'h00c};
  int err_count = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  asf_top asf_top_inst (
    .clk_sys_i(clk), .rst_n_i(rst_n),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_bresp_o(br), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .push_i(push),
    .seq1_input_select_o(sel1), .seq2_input_select_o(),
    .seq1_sample_control_o(), .seq2_sample_control_o(),
    .seq1_convert_mask_o(cmask1), .seq2_convert_mask_o(),
    .sample_irq_o(), .fifo_overflow_o(), .fifo_underflow_o(),
    .irq_o(irq));

  // ========================================================================
  // Bus and push tasks
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // Each channel is dropped only at the edge where its ready is seen
  // Settled values at the falling edge are what the next rising edge sees
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic aw_take, w_take, done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bre <= 1'b1;
    do begin
      @(negedge clk);
      n++;
      aw_take = awv && awr;
      w_take = wv && wr;
      done = bv;
      @(posedge clk);
      if (aw_take) awv <= 1'b0;
      if (w_take) wv <= 1'b0;
    end while (!done && n < 50);
    if (!done) err_count++;
    bre <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a);
    int n;
    logic ar_take, done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    do begin
      @(negedge clk);
      n++;
      ar_take = arv && arr;
      done = rv;
      v = rd;
      resp = rr;
      @(posedge clk);
      if (ar_take) arv <= 1'b0;
    end while (!done && n < 50);
    if (!done) err_count++;
    rre <= 1'b0;
  endtask : rd_reg

  task automatic chk_rd(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
    rd_reg(a);
    check(what, v, exp);
  endtask : chk_rd

  // One idle cycle between strobes keeps each push a single pulse
  task automatic push_res(input logic [1:0] s, input logic [2:0] smp,
                          input logic [9:0] d);
    @(posedge clk);
    push <= {1'b1, s, smp, d};
    @(posedge clk);
    push <= '0;
  endtask : push_res

  // ========================================================================
  // Watchdog at 5000 cycles, far above the 150 or so cycles the tests need
  initial begin
    #100000;
    err_count++;
    stop_test();
  end

  // ========================================================================
  // Tests
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd("stat0", `ASF_OFS_SEQ0_STATUS, 32'h0000_0100);
    chk_rd("stat1", `ASF_OFS_SEQ1_STATUS, 32'h0000_0100);
    chk_rd("stat2", `ASF_OFS_SEQ2_STATUS, 32'h0000_0100);
    for (int i = 0; i < 9; i++) push_res(2'd0, i[2:0], 10'h100 + i[9:0]);
    chk_rd("stat0 full", `ASF_OFS_SEQ0_STATUS, 32'h0000_1000);
    for (int i = 0; i < 8; i++) begin
      chk_rd("res0", `ASF_OFS_SEQ0_RESULT, 32'h0000_0100 + i);
      if (i == 2) chk_rd("stat0 mid", `ASF_OFS_SEQ0_STATUS, 32'h0000_0003);
    end
    chk_rd("stat0 empty", `ASF_OFS_SEQ0_STATUS, 32'h0000_0100);
    rd_reg(`ASF_OFS_SEQ0_RESULT);
    chk_rd("stat0 udf", `ASF_OFS_SEQ0_STATUS, 32'h0000_0100);
    wr_reg(`ASF_OFS_SEQ1_CONTROL, 32'h0000_0024);
    chk_rd("ctl1", `ASF_OFS_SEQ1_CONTROL, 32'h0000_0024);
    check("mask1", {28'h0, cmask1}, 32'h0000_0003);
    wr_reg(`ASF_OFS_SEQ1_SELECT, 32'h1234_beef);
    chk_rd("sel1", `ASF_OFS_SEQ1_SELECT, 32'h0000_beef);
    check("sel1 pin", {16'h0, sel1}, 32'h0000_beef);
    push_res(2'd1, 3'd0, 10'h3ff);
    push_res(2'd1, 3'd1, 10'h001);
    push_res(2'd1, 3'd2, 10'h155);
    chk_rd("stat1 end", `ASF_OFS_SEQ1_STATUS, 32'h0000_0020);
    chk_rd("res1", `ASF_OFS_SEQ1_RESULT, 32'h0000_03ff);
    chk_rd("stat1 rd", `ASF_OFS_SEQ1_STATUS, 32'h0000_0021);
    chk_rd("stat2 alone", `ASF_OFS_SEQ2_STATUS, 32'h0000_0100);
    push_res(2'd1, 3'd0, 10'h00a);
    push_res(2'd1, 3'd1, 10'h00b);
    push_res(2'd1, 3'd0, 10'h00c);
    chk_rd("stat1 wrap", `ASF_OFS_SEQ1_STATUS, 32'h0000_1011);
    for (int i = 0; i < 4; i++) begin
      chk_rd("res1 order", `ASF_OFS_SEQ1_RESULT, {22'h0, exp1[i]});
    end
    chk_rd("irq st", `ASF_OFS_IRQ_STATUS, 32'h0000_0111);
    check("irq idle", {31'h0, irq}, 32'h0000_0000);
    wr_reg(`ASF_OFS_IRQ_MASK, 32'h0000_0100);
    repeat (2) @(posedge clk);
    check("irq on", {31'h0, irq}, 32'h0000_0001);
    wr_reg(`ASF_OFS_IRQ_STATUS, 32'h0000_0100);
    repeat (2) @(posedge clk);
    check("irq off", {31'h0, irq}, 32'h0000_0000);
    chk_rd("irq clr", `ASF_OFS_IRQ_STATUS, 32'h0000_0011);
    wr_reg(`ASF_OFS_SEQ0_STATUS, 32'h0000_ffff);
    chk_rd("stat0 ro", `ASF_OFS_SEQ0_STATUS, 32'h0000_0100);
    rd_reg(12'h010);
    check("unmapped", {30'h0, resp}, 32'h0000_0002);
    stop_test();
  end

endmodule : tb_adc_sequencer_result_fifos

`default_nettype wire

/* File: verilog/asf_consts.svh */
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define ASF_OFS_SEQ0_RESULT    12'h048
`define ASF_OFS_SEQ0_STATUS    12'h04c
`define ASF_OFS_SEQ1_SELECT    12'h060
`define ASF_OFS_SEQ1_CONTROL   12'h064
`define ASF_OFS_SEQ1_RESULT    12'h068
`define ASF_OFS_SEQ1_STATUS    12'h06c
`define ASF_OFS_SEQ2_SELECT    12'h080
`define ASF_OFS_SEQ2_CONTROL   12'h084
`define ASF_OFS_SEQ2_RESULT    12'h088
`define ASF_OFS_SEQ2_STATUS    12'h08c
`define ASF_OFS_IRQ_STATUS     12'h0c0
`define ASF_OFS_IRQ_MASK       12'h0c4

// ==========================================================================
// FIFO status fields and reset value
`define ASF_STAT_FULL_BIT      12
`define ASF_STAT_EMPTY_BIT     8
`define ASF_STAT_WPTR_LSB      4
`define ASF_STAT_RPTR_LSB      0
`define ASF_FSTAT_RESET        32'h0000_0100

// ==========================================================================
// FIFO depths, one slot per sample step of the sequencer
`define ASF_DEPTH_SEQ0         4'h8
`define ASF_DEPTH_SEQ12        4'h4

// ==========================================================================
// Sample control nibble fields
`define ASF_CTL_END_BIT        1
`define ASF_CTL_IE_BIT         2
`define ASF_CFG_RESET          16'h0000

// ==========================================================================
// Interrupt status and mask layout
`define ASF_IRQ_W              10
`define ASF_IRQ_OVF_LSB        0
`define ASF_IRQ_UDF_LSB        4
`define ASF_IRQ_SMP_LSB        8
`define ASF_IRQ_RESET          10'h000

// ==========================================================================
// Bus responses
`define ASF_RESP_OKAY          2'h0
`define ASF_RESP_SLVERR        2'h2

`endif

/* File: verilog/asf_pkg.sv */
`default_nettype none

package asf_pkg;

  // ========================================================================
  // Result pushed by the converter
  typedef struct packed {
    logic valid;
    logic [1:0] seq;
    logic [2:0] sample;
    logic [9:0] data;
  } asf_push_t;

  typedef logic [3:0] asf_ptr_t;

  typedef enum {
    ASF_REG_NONE,
    ASF_REG_RES0,
    ASF_REG_STAT0,
    ASF_REG_SEL1,
    ASF_REG_CTL1,
    ASF_REG_RES1,
    ASF_REG_STAT1,
    ASF_REG_SEL2,
    ASF_REG_CTL2,
    ASF_REG_RES2,
    ASF_REG_STAT2,
    ASF_REG_IRQ_ST,
    ASF_REG_IRQ_MASK
  } asf_reg_t;

endpackage : asf_pkg

`default_nettype wire

/* File: verilog/asf_top.sv */
`include "asf_consts.svh"
`default_nettype none

// Functional notes
// - Each result read pops the oldest 10-bit value, in the order pushed.
// - Push into full FIFO flags overflow; read of empty FIFO flags underflow.
// - Unused upper result and status bits read as zero.
// - After reset every FIFO status word reads 0x100.
// - Status bit 12 is set exactly while the FIFO is full.
// - Status bit 8 resets to one and is set exactly while empty.
// - Status bits 7:4 show the slot the next result is written to.
// - Status bits 3:0 show the slot the next read returns.
// - Sequencers 1 and 2 have 16-bit select and control, four nibbles.
// - Sequencers 0, 1 and 2 have independent FIFOs and status words.
// - Samples after the one marked last are never converted.
// - Per-sample interrupt enable raises the raw interrupt at conversion end.
module asf_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // AXI4-Lite write channels
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // AXI4-Lite read channels
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [11:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // Converter side
  input wire asf_pkg::asf_push_t push_i,
  output logic [15:0] seq1_input_select_o,
  output logic [15:0] seq2_input_select_o,
  output logic [15:0] seq1_sample_control_o,
  output logic [15:0] seq2_sample_control_o,
  output logic [3:0] seq1_convert_mask_o,
  output logic [3:0] seq2_convert_mask_o,
  output logic [1:0] sample_irq_o,
  // Flags to the overflow and underflow status registers
  output logic [2:0] fifo_overflow_o,
  output logic [2:0] fifo_underflow_o,
  // Interrupt
  output logic irq_o
);
  import asf_pkg::*;

  // ========================================================================
  // Helpers
  function automatic asf_reg_t decode(input logic [11:0] a);
    case (a)
      `ASF_OFS_SEQ0_RESULT: decode = ASF_REG_RES0;
      `ASF_OFS_SEQ0_STATUS: decode = ASF_REG_STAT0;
      `ASF_OFS_SEQ1_SELECT: decode = ASF_REG_SEL1;
      `ASF_OFS_SEQ1_CONTROL: decode = ASF_REG_CTL1;
      `ASF_OFS_SEQ1_RESULT: decode = ASF_REG_RES1;
      `ASF_OFS_SEQ1_STATUS: decode = ASF_REG_STAT1;
      `ASF_OFS_SEQ2_SELECT: decode = ASF_REG_SEL2;
      `ASF_OFS_SEQ2_CONTROL: decode = ASF_REG_CTL2;
      `ASF_OFS_SEQ2_RESULT: decode = ASF_REG_RES2;
      `ASF_OFS_SEQ2_STATUS: decode = ASF_REG_STAT2;
      `ASF_OFS_IRQ_STATUS: decode = ASF_REG_IRQ_ST;
      `ASF_OFS_IRQ_MASK: decode = ASF_REG_IRQ_MASK;
      default: decode = ASF_REG_NONE;
    endcase
  endfunction : decode

  function automatic asf_ptr_t depth(input int i);
    depth = (i == 0) ? `ASF_DEPTH_SEQ0 : `ASF_DEPTH_SEQ12;
  endfunction : depth

  function automatic asf_ptr_t bump(input asf_ptr_t p, input asf_ptr_t d);
    bump = (p == d - 4'h1) ? 4'h0 : p + 4'h1;
  endfunction : bump

  // Samples up to and including the first END; none marked means all four
  function automatic logic [3:0] conv_mask(input logic [15:0] ctl);
    logic stop;
    stop = 1'b0;
    conv_mask = 4'h0;
    for (int k = 0; k < 4; k++) begin
      if (!stop) begin
        conv_mask[k] = 1'b1;
      end
      if (ctl[4 * k + `ASF_CTL_END_BIT]) begin
        stop = 1'b1;
      end
    end
  endfunction : conv_mask

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = nw[15:8];
    end
  endfunction : merge16

  // ========================================================================
  // State
  logic [9:0] mem_ff [3][8];
  logic [9:0] nxt_mem [3][8];
  asf_ptr_t wptr_ff [3];
  asf_ptr_t nxt_wptr [3];
  asf_ptr_t rptr_ff [3];
  asf_ptr_t nxt_rptr [3];
  asf_ptr_t cnt_ff [3];
  asf_ptr_t nxt_cnt [3];
  logic [2:0] ovf_ff, nxt_ovf, udf_ff, nxt_udf;
  logic [1:0] sirq_ff, nxt_sirq;
  logic [15:0] sel_ff [2];
  logic [15:0] nxt_sel [2];
  logic [15:0] ctl_ff [2];
  logic [15:0] nxt_ctl [2];
  logic [3:0] cmask_ff [2];
  logic [3:0] nxt_cmask [2];
  logic [`ASF_IRQ_W-1:0] irq_st_ff, nxt_irq_st, irq_mask_ff, nxt_irq_mask;
  logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
  logic [11:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  logic aw_hs, w_hs, ar_hs, wr_go;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  asf_reg_t wr_reg, rd_reg;
  logic [2:0] allow, push_ok, pop_req, do_push, do_pop;
  logic [31:0] stat_w [3];
  logic [31:0] rd_word;
  logic [`ASF_IRQ_W-1:0] irq_set;
  logic [`ASF_IRQ_W-1:0] irq_bmask;

  // ========================================================================
  // Bus handshakes
  assign s_axi_awready_o = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready_o = !w_held_ff && !bvalid_ff;
  assign s_axi_arready_o = !rvalid_ff;
  assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr_i;
  assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata_i;
  assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb_i;
  assign irq_bmask = {{2{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_go = (aw_held_ff || aw_hs) && (w_held_ff || w_hs);
  assign wr_reg = decode(wr_addr);
  assign rd_reg = decode(s_axi_araddr_i);

  assign pop_req[0] = ar_hs && (rd_reg == ASF_REG_RES0);
  assign pop_req[1] = ar_hs && (rd_reg == ASF_REG_RES1);
  assign pop_req[2] = ar_hs && (rd_reg == ASF_REG_RES2);

  // Results past the END sample are dropped, not stored
  assign allow[0] = 1'b1;
  assign allow[1] = !push_i.sample[2] && cmask_ff[0][push_i.sample[1:0]];
  assign allow[2] = !push_i.sample[2] && cmask_ff[1][push_i.sample[1:0]];

  // ========================================================================
  // Result FIFOs
  always_comb begin
    nxt_mem = mem_ff;
    nxt_ovf = 3'h0;
    nxt_udf = 3'h0;
    for (int i = 0; i < 3; i++) begin
      push_ok[i] = push_i.valid && (push_i.seq == 2'(i)) && allow[i];
      nxt_ovf[i] = push_ok[i] && (cnt_ff[i] == depth(i));
      nxt_udf[i] = pop_req[i] && (cnt_ff[i] == 4'h0);
      do_push[i] = push_ok[i] && !nxt_ovf[i];
      do_pop[i] = pop_req[i] && !nxt_udf[i];
      nxt_wptr[i] = wptr_ff[i];
      nxt_rptr[i] = rptr_ff[i];
      if (do_push[i]) begin
        nxt_mem[i][wptr_ff[i][2:0]] = push_i.data;
        nxt_wptr[i] = bump(wptr_ff[i], depth(i));
      end
      if (do_pop[i]) begin
        nxt_rptr[i] = bump(rptr_ff[i], depth(i));
      end
      nxt_cnt[i] = cnt_ff[i] + {3'h0, do_push[i]} - {3'h0, do_pop[i]};
    end
    // Raw interrupt when an enabled sample finishes conversion
    for (int s = 0; s < 2; s++) begin
      nxt_sirq[s] = push_ok[s + 1] &&
        ctl_ff[s][{push_i.sample[1:0], 2'h2}];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 3; i++) begin
        for (int j = 0; j < 8; j++) begin
          mem_ff[i][j] <= 10'h000;
        end
        wptr_ff[i] <= 4'h0;
        rptr_ff[i] <= 4'h0;
        cnt_ff[i] <= 4'h0;
      end
      ovf_ff <= 3'h0;
      udf_ff <= 3'h0;
      sirq_ff <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      cnt_ff <= nxt_cnt;
      ovf_ff <= nxt_ovf;
      udf_ff <= nxt_udf;
      sirq_ff <= nxt_sirq;
    end
  end

  // ========================================================================
  // Status words, reserved bits read as zero
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      stat_w[i] = 32'h0000_0000;
      stat_w[i][`ASF_STAT_FULL_BIT] = (cnt_ff[i] == depth(i));
      stat_w[i][`ASF_STAT_EMPTY_BIT] = (cnt_ff[i] == 4'h0);
      stat_w[i][`ASF_STAT_WPTR_LSB +: 4] = wptr_ff[i];
      stat_w[i][`ASF_STAT_RPTR_LSB +: 4] = rptr_ff[i];
    end
  end

  // An underflowing read returns the stale slot at the read pointer
  always_comb begin
    case (rd_reg)
      ASF_REG_RES0: rd_word = {22'h0, mem_ff[0][rptr_ff[0][2:0]]};
      ASF_REG_RES1: rd_word = {22'h0, mem_ff[1][rptr_ff[1][2:0]]};
      ASF_REG_RES2: rd_word = {22'h0, mem_ff[2][rptr_ff[2][2:0]]};
      ASF_REG_STAT0: rd_word = stat_w[0];
      ASF_REG_STAT1: rd_word = stat_w[1];
      ASF_REG_STAT2: rd_word = stat_w[2];
      ASF_REG_SEL1: rd_word = {16'h0, sel_ff[0]};
      ASF_REG_CTL1: rd_word = {16'h0, ctl_ff[0]};
      ASF_REG_SEL2: rd_word = {16'h0, sel_ff[1]};
      ASF_REG_CTL2: rd_word = {16'h0, ctl_ff[1]};
      ASF_REG_IRQ_ST: rd_word = {22'h0, irq_st_ff};
      ASF_REG_IRQ_MASK: rd_word = {22'h0, irq_mask_ff};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ========================================================================
  // Bus slave
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_awaddr = aw_hs ? s_axi_awaddr_i : awaddr_ff;
    nxt_wdata = w_hs ? s_axi_wdata_i : wdata_ff;
    nxt_wstrb = w_hs ? s_axi_wstrb_i : wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (aw_hs) begin
      nxt_aw_held = 1'b1;
    end
    if (w_hs) begin
      nxt_w_held = 1'b1;
    end
    if (wr_go) begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (wr_reg == ASF_REG_NONE) ? `ASF_RESP_SLVERR
                                           : `ASF_RESP_OKAY;
    end else if (s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
    if (ar_hs) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_word;
      nxt_rresp = (rd_reg == ASF_REG_NONE) ? `ASF_RESP_SLVERR
                                           : `ASF_RESP_OKAY;
    end else if (s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `ASF_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= `ASF_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // ========================================================================
  // Sequencer configuration and interrupt registers
  always_comb begin
    nxt_sel = sel_ff;
    nxt_ctl = ctl_ff;
    nxt_irq_mask = irq_mask_ff;
    irq_set = `ASF_IRQ_RESET;
    irq_set[`ASF_IRQ_OVF_LSB +: 3] = nxt_ovf;
    irq_set[`ASF_IRQ_UDF_LSB +: 3] = nxt_udf;
    irq_set[`ASF_IRQ_SMP_LSB +: 2] = nxt_sirq;
    nxt_irq_st = irq_st_ff;
    if (wr_go) begin
      case (wr_reg)
        ASF_REG_SEL1: nxt_sel[0] = merge16(sel_ff[0], wr_data[15:0],
                                           wr_strb[1:0]);
        ASF_REG_CTL1: nxt_ctl[0] = merge16(ctl_ff[0], wr_data[15:0],
                                           wr_strb[1:0]);
        ASF_REG_SEL2: nxt_sel[1] = merge16(sel_ff[1], wr_data[15:0],
                                           wr_strb[1:0]);
        ASF_REG_CTL2: nxt_ctl[1] = merge16(ctl_ff[1], wr_data[15:0],
                                           wr_strb[1:0]);
        ASF_REG_IRQ_ST: nxt_irq_st = irq_st_ff &
          ~(wr_data[`ASF_IRQ_W-1:0] & irq_bmask);
        ASF_REG_IRQ_MASK: nxt_irq_mask = (irq_mask_ff & ~irq_bmask) |
          (wr_data[`ASF_IRQ_W-1:0] & irq_bmask);
        default: nxt_irq_st = irq_st_ff;
      endcase
    end
    // A new event beats a clear in the same cycle
    nxt_irq_st = nxt_irq_st | irq_set;
    for (int s = 0; s < 2; s++) begin
      nxt_cmask[s] = conv_mask(nxt_ctl[s]);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int s = 0; s < 2; s++) begin
        sel_ff[s] <= `ASF_CFG_RESET;
        ctl_ff[s] <= `ASF_CFG_RESET;
        cmask_ff[s] <= 4'hf;
      end
      irq_st_ff <= `ASF_IRQ_RESET;
      irq_mask_ff <= `ASF_IRQ_RESET;
    end else begin
      sel_ff <= nxt_sel;
      ctl_ff <= nxt_ctl;
      cmask_ff <= nxt_cmask;
      irq_st_ff <= nxt_irq_st;
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // ========================================================================
  // Outputs
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign seq1_input_select_o = sel_ff[0];
  assign seq2_input_select_o = sel_ff[1];
  assign seq1_sample_control_o = ctl_ff[0];
  assign seq2_sample_control_o = ctl_ff[1];
  assign seq1_convert_mask_o = cmask_ff[0];
  assign seq2_convert_mask_o = cmask_ff[1];
  assign sample_irq_o = sirq_ff;
  assign fifo_overflow_o = ovf_ff;
  assign fifo_underflow_o = udf_ff;
  assign irq_o = |(irq_st_ff & irq_mask_ff);

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  logic [9:0] head0;
  assign head0 = mem_ff[0][rptr_ff[0][2:0]];

  property p_reset_stat;
    !$past(rst_n_i) |-> stat_w[0] == `ASF_FSTAT_RESET &&
      stat_w[1] == `ASF_FSTAT_RESET && stat_w[2] == `ASF_FSTAT_RESET;
  endproperty
  a_reset_stat: assert property (p_reset_stat)
    else $error("status word not 0x100 after reset");

  property p_pop_order;
    (pop_req[0] && cnt_ff[0] != 4'h0) |=>
      s_axi_rvalid_o && s_axi_rdata_o[9:0] == $past(head0);
  endproperty
  a_pop_order: assert property (p_pop_order)
    else $error("result read did not return oldest entry");

  property p_ovf;
    (push_ok[0] && cnt_ff[0] == `ASF_DEPTH_SEQ0) |=>
      fifo_overflow_o[0] && $stable(wptr_ff[0]) &&
      cnt_ff[0] == 4'h8 - {3'h0, $past(do_pop[0])};
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged or pointer moved");

  property p_udf;
    (pop_req[0] && cnt_ff[0] == 4'h0) |=>
      fifo_underflow_o[0] && $stable(rptr_ff[0]);
  endproperty
  a_udf: assert property (p_udf)
    else $error("underflow not flagged or pointer moved");

  property p_full;
    (cnt_ff[1] == 4'h3 && do_push[1] && !do_pop[1]) |=>
      stat_w[1][12] && !stat_w[1][8];
  endproperty
  a_full: assert property (p_full)
    else $error("full flag wrong after fourth entry");

  property p_empty;
    (cnt_ff[1] == 4'h1 && do_pop[1] && !do_push[1]) |=>
      stat_w[1][8] && !stat_w[1][12];
  endproperty
  a_empty: assert property (p_empty)
    else $error("empty flag wrong after last read");

  property p_wptr;
    do_push[0] |=> wptr_ff[0] ==
      (($past(wptr_ff[0]) == 4'h7) ? 4'h0 : $past(wptr_ff[0]) + 4'h1);
  endproperty
  a_wptr: assert property (p_wptr)
    else $error("write pointer did not advance modulo 8");

  property p_rptr;
    do_pop[1] |=> rptr_ff[1] ==
      (($past(rptr_ff[1]) == 4'h3) ? 4'h0 : $past(rptr_ff[1]) + 4'h1);
  endproperty
  a_rptr: assert property (p_rptr)
    else $error("read pointer did not advance modulo 4");

  property p_resv;
    stat_w[0][31:13] == 19'h0 && stat_w[2][11:9] == 3'h0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved status bits not zero");

  property p_end;
    (push_i.valid && push_i.seq == 2'h1 && !allow[1] && !do_pop[1]) |=>
      $stable(cnt_ff[1]) && !fifo_overflow_o[1] && !sample_irq_o[0];
  endproperty
  a_end: assert property (p_end)
    else $error("sample after END was stored");

  property p_sirq;
    (push_ok[1] && ctl_ff[0][{push_i.sample[1:0], 2'h2}]) |=>
      sample_irq_o[0] ##1 irq_st_ff[`ASF_IRQ_SMP_LSB];
  endproperty
  a_sirq: assert property (p_sirq)
    else $error("sample interrupt not raised");

  property p_cfg;
    (wr_go && wr_reg == ASF_REG_CTL1 && wr_strb[1:0] == 2'h3) |=>
      seq1_sample_control_o == $past(wr_data[15:0]) && s_axi_bvalid_o;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("control write not stored");

  property p_indep;
    (do_push[0] && !do_push[1] && !do_pop[1]) |=> $stable(cnt_ff[1]);
  endproperty
  a_indep: assert property (p_indep)
    else $error("push to one FIFO disturbed another");

  c_full0: cover property (cnt_ff[0] == `ASF_DEPTH_SEQ0);
  c_ovf: cover property (fifo_overflow_o[0]);
  c_udf: cover property (fifo_underflow_o[0]);
  c_irq: cover property ($rose(irq_o));

endmodule : asf_top

`default_nettype wire
